// File: bench/bcs_ready_model.sv
/* Slow memory that pulls ready low for wait_len ticks after each cycle start.
   Assumes wait_len of 4 or less, set by the bench. */
`timescale 1ns/100ps
module bcs_ready_model (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic cycle_start,
    input wire logic [2:0] wait_len,
    output logic mem_ready_in
);
    logic [2:0] left;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            left <= 3'h0;
        else if (cycle_start)
            left <= wait_len;
        else if (left != 3'h0)
            left <= left - 3'h1;
    end
    // Decoded from the count registered on the oscillator clock, high when idle
    assign mem_ready_in = (left == 3'h0);
endmodule

// File: bench/bcs_top_monitor.sv
/* Checker on the top ports of the E clock block.
   Assumes clk_en is held high and bound to bcs_top. */
`timescale 1ns/100ps
module bcs_top_monitor (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic mem_ready_in,
    input wire logic e_clk,
    input wire logic cycle_start,
    input wire bcs_pkg::bcs_bus_t bus_out,
    input wire logic data_oe,
    input wire logic ram_hit
);
    import bcs_pkg::*;
    logic [3:0] hi_n;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Counts ticks of the current E high phase
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            hi_n <= 4'h0;
        else
            hi_n <= e_clk ? hi_n + 4'h1 : 4'h0;
    end
    // ********
    // Assertions
    // ********
    sequence s_rise_ready;
        mem_ready_in[*4] ##0 $rose(e_clk);
    endsequence
    sequence s_rise_wait;
        !mem_ready_in[*2] ##0 $rose(e_clk);
    endsequence
    chk_low_two: assert property ($fell(e_clk) |=> !e_clk ##1 e_clk)
        else $error("E low phase wrong");
    chk_high_even: assert property ($fell(e_clk) |-> !hi_n[0])
        else $error("E high not whole halves");
    chk_run_plain: assert property (s_rise_ready |=> e_clk ##1 !e_clk)
        else $error("E stretched with ready high");
    chk_stretch_go: assert property (s_rise_wait |=> e_clk[*3])
        else $error("E not stretched");
    chk_resume_bound: assert property (e_clk && mem_ready_in |-> ##[0:8] !e_clk)
        else $error("E did not resume");
    chk_start_fall: assert property (cycle_start |-> $fell(e_clk))
        else $error("cycle start without E fall");
    chk_fall_start: assert property ($fell(e_clk) |-> cycle_start)
        else $error("E fall without cycle start");
    chk_bus_hold: assert property (e_clk |-> $stable(bus_out))
        else $error("bus moved while E high");
    chk_oe_read: assert property (data_oe |-> ram_hit && !bus_out.write)
        else $error("data driven outside RAM read");
endmodule
bind bcs_top bcs_top_monitor i_bcs_top_monitor (.sys_clk(sys_clk),
    .arst_n(arst_n), .mem_ready_in(mem_ready_in), .e_clk(e_clk),
    .cycle_start(cycle_start), .bus_out(bus_out), .data_oe(data_oe),
    .ram_hit(ram_hit));

// File: bench/test_bus_clock_stretch_ram_enable.sv
/* Self-checking bench for the E clock block.
   Assumes the package, design and ready model are compiled first. */
`timescale 1ns/100ps
module test_bus_clock_stretch_ram_enable;
    import bcs_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic onchip_ram_gate = 1'b1;
    logic mem_ready_in, e_clk, cycle_start, data_oe, ram_hit;
    logic [2:0] wait_len = 3'h0;
    bcs_req_t cpu_req = '0;
    bcs_bus_t bus_out;
    logic [7:0] data_out, ram_rdata;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 32'h89ea;
    always #5 sys_clk = ~sys_clk;
    bcs_top i_bcs_top (.sys_clk, .arst_n, .clk_en(1'b1),
        .osc_return(1'b0),
        .mem_ready_in, .onchip_ram_gate, .cpu_req,
        .e_clk, .cycle_start, .bus_out, .data_out, .data_oe, .ram_rdata,
        .ram_hit);
    bcs_ready_model i_bcs_ready_model (.sys_clk, .arst_n, .cycle_start,
        .wait_len, .mem_ready_in);
    task automatic results;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic bcs_req_t mk(logic wr, logic [15:0] a, logic [7:0] d);
        return '{1'b1, wr, a, d};
    endfunction
    // One bus cycle; returns its length and any RAM read data
    task automatic cyc(input bcs_req_t r, output int per,
        output logic [7:0] got, output logic oe);
        int n;
        n = 0;
        per = 0;
        oe = 1'b0;
        got = 8'h00;
        @(posedge sys_clk);
        cpu_req <= r;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (cycle_start !== 1'b1 && n < 40);
        do begin
            @(posedge sys_clk);
            cpu_req <= '0;
            #1;
            per++;
            if (data_oe === 1'b1) begin
                oe = 1'b1;
                got = data_out;
            end
        end while (cycle_start !== 1'b1 && per < 40);
        if (n >= 40 || per >= 40) begin
            num_errors++;
            results();
        end
    endtask
    initial begin
        int per, w;
        logic [7:0] d, got;
        logic [15:0] a;
        logic oe;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            a = {9'h0, 7'($random(seed))};
            d = 8'($random(seed));
            w = (i == 0) ? 0 : ($random(seed) & 1) * 4;
            wait_len <= 3'(w);
            cyc(mk(1'b1, a, d), per, got, oe);
            if (w == 0)
                cmp(per, 4);
            else
                cmp({per >= 6, per[0]}, 2);
            cyc(mk(1'b0, a, 8'h00), per, got, oe);
            cmp({oe, got}, {1'b1, d});
        end
        $display("test stretch and ram done");
        onchip_ram_gate <= 1'b0;
        cyc(mk(1'b1, a, ~d), per, got, oe);
        cyc(mk(1'b0, a, 8'h00), per, got, oe);
        cmp(oe, 0);
        onchip_ram_gate <= 1'b1;
        cyc(mk(1'b0, a, 8'h00), per, got, oe);
        cmp({oe, got}, {1'b1, d});
        cyc(mk(1'b0, 16'h0100, 8'h00), per, got, oe);
        cmp(oe, 0);
        $display("test ram gate done");
        results();
    end
endmodule

// File: hw/bcs_pkg.sv
/*
 * Package for the bus clock stretch and on-chip RAM gate block.
 * Assumes a single system clock; no software-visible registers.
 */
package bcs_pkg;
    // ****************************************************
    // Clock division
    // ****************************************************
    // Oscillator ticks in one unstretched E period
    localparam int unsigned OSC_PER_E = 4;
    // Oscillator ticks in one half period of E
    localparam int unsigned OSC_PER_HALF = OSC_PER_E / 2;
    localparam logic [1:0] PHASE_RESET = 2'h0;

    // ****************************************************
    // On-chip RAM
    // ****************************************************
    localparam int unsigned RAM_ADDR_W = 7;
    localparam int unsigned RAM_WORDS = 128;
    localparam logic [15:0] RAM_BASE = 16'h0000;
    localparam logic [15:0] RAM_TOP = 16'h007f;

    typedef enum logic [2:0] {
        BCS_RUN = 3'b001,
        BCS_HOLD = 3'b010,
        BCS_LEAVE = 3'b100
    } bcs_state_t;

    // Processor side access request
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bcs_req_t;

    // Bus outputs for the current cycle
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
    } bcs_bus_t;
endpackage

// File: hw/bcs_ram.sv
/*
 * 128 x 8 on-chip RAM with registered read data.
 * Assumes one clock; writes and reads happen when the enable is high.
 */
`timescale 1ns/100ps
module bcs_ram #(
    parameter int unsigned AW = 7,
    parameter int unsigned WORDS = 128
) (
    input wire logic clk,
    input wire logic en,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [WORDS];

    always_ff @(posedge clk) begin
        if (en) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule

// File: hw/bcs_top.sv
/*
 * E bus clock generator with memory-ready stretching and on-chip RAM gate.
 * Assumes sys_clk is the oscillator input (four times E); osc_return is
 * grounded by the board. mem_ready_in and onchip_ram_gate come from pins.
 */
// Behaviour
// - E is the oscillator divided by four.
// - An external TTL source on the oscillator input clocks the block.
// - With memory-ready high E runs unstretched.
// - With memory-ready low E grows only in whole half periods.
// - A stretch starts at the end of E high when ready met setup.
// - A late ready fall defers the stretch to the next E-high half.
// - E resumes at the end of the half in which ready returns in time.
// - A late ready return drops E at the second possible transition.
// - The on-chip RAM answers only while the RAM gate is high.
// - E is a single-phase system clock conditioned by memory-ready.
// - On-chip RAM reads drive the data bus out.
`timescale 1ns/100ps
module bcs_top #(
    parameter int unsigned RAM_AW = bcs_pkg::RAM_ADDR_W,
    parameter int unsigned RAM_N = bcs_pkg::RAM_WORDS
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic osc_return,
    input wire logic mem_ready_in,
    input wire logic onchip_ram_gate,
    input wire bcs_pkg::bcs_req_t cpu_req,
    output logic e_clk,
    output logic cycle_start,
    output bcs_pkg::bcs_bus_t bus_out,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic [7:0] ram_rdata,
    output logic ram_hit
);
    import bcs_pkg::*;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic rdy_s1;
        logic rdy_s2;
        logic gate_s1;
        logic gate_s2;
        logic [1:0] phase;
        bcs_state_t state;
        logic e_clk;
        logic cycle_start;
        bcs_bus_t bus;
        logic [7:0] wdata;
        logic [7:0] dout;
        logic doe;
        logic hit;
    } bcs_regs_t;

    bcs_regs_t r;
    bcs_regs_t next_r;
    logic ram_en;
    logic ram_we;
    logic rst_n;

    function automatic logic in_ram(input logic [15:0] a);
        in_ram = (a >= RAM_BASE) && (a <= RAM_TOP);
    endfunction

    assign rst_n = r.rst_s2;

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        next_r = r;
        next_r.rst_s1 = 1'b1;
        next_r.rst_s2 = r.rst_s1;
        next_r.rdy_s1 = mem_ready_in;
        next_r.rdy_s2 = r.rdy_s1;
        next_r.gate_s1 = onchip_ram_gate;
        next_r.gate_s2 = r.gate_s1;
        next_r.cycle_start = 1'b0;
        case (r.state)
            BCS_RUN: begin
                // Phase 0,1 low; 2,3 high; divide by four
                next_r.phase = r.phase + 2'h1;
                // Ready low at the last high tick: hold E high
                if (r.phase == 2'h3 && !r.rdy_s2) begin
                    // Restart the high half so the stretch stays whole
                    next_r.phase = 2'h2;
                    next_r.state = BCS_HOLD;
                end
                if (r.phase == 2'h3 && r.rdy_s2) begin
                    next_r.cycle_start = 1'b1;
                    next_r.wdata = cpu_req.wdata;
                    next_r.bus.valid = cpu_req.valid;
                    next_r.bus.write = cpu_req.write;
                    next_r.bus.addr = cpu_req.addr;
                end
            end
            BCS_HOLD: begin
                // Each hold tick pair is one half period of E
                if (r.phase == 2'h3) begin
                    next_r.phase = 2'h2;
                end else begin
                    next_r.phase = 2'h3;
                    if (r.rdy_s2) begin
                        next_r.state = BCS_LEAVE;
                    end
                end
            end
            BCS_LEAVE: begin
                // Finish the current half, then fall
                next_r.phase = 2'h0;
                next_r.state = BCS_RUN;
                next_r.cycle_start = 1'b1;
                next_r.wdata = cpu_req.wdata;
                next_r.bus.valid = cpu_req.valid;
                next_r.bus.write = cpu_req.write;
                next_r.bus.addr = cpu_req.addr;
            end
            default: begin
                next_r.state = BCS_RUN;
                next_r.phase = PHASE_RESET;
            end
        endcase
        next_r.e_clk = next_r.phase[1];
        // Internal RAM read hit drives the data bus
        next_r.hit = next_r.bus.valid && in_ram(next_r.bus.addr)
            && r.gate_s2;
        next_r.doe = next_r.hit && !next_r.bus.write;
        next_r.dout = ram_rdata;
    end

    // Read early in the cycle so data_out settles before E falls
    assign ram_en = r.hit && clk_en;
    // Write on the last high tick, including the end of a stretch
    assign ram_we = r.bus.write && r.phase == 2'h3
        && ((r.state == BCS_RUN && r.rdy_s2) || r.state == BCS_LEAVE);

    bcs_ram #(
        .AW(RAM_AW),
        .WORDS(RAM_N)
    ) u_ram (
        .clk(sys_clk),
        .en(ram_en),
        .we(ram_we),
        .addr(r.bus.addr[RAM_AW-1:0]),
        .wdata(r.wdata),
        .rdata(ram_rdata)
    );

    // ****************************************************
    // State register
    // ****************************************************
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
            r.state <= BCS_RUN;
            r.rdy_s1 <= 1'b1;
            r.rdy_s2 <= 1'b1;
        end else if (clk_en) begin
            if (!rst_n) begin
                r <= '0;
                r.rst_s1 <= 1'b1;
                r.rst_s2 <= r.rst_s1;
                r.state <= BCS_RUN;
                r.rdy_s1 <= 1'b1;
                r.rdy_s2 <= 1'b1;
            end else begin
                r <= next_r;
            end
        end
    end

    assign e_clk = r.e_clk;
    assign cycle_start = r.cycle_start;
    assign bus_out = r.bus;
    assign data_out = r.dout;
    assign data_oe = r.doe;
    assign ram_hit = r.hit;
endmodule
